// ---- logic/dst_core.sv ----
// Divide primitives and trapping operations datapath
// What this block does
// RULE1 - Step subtracts when quotient flag set, else adds
// RULE2 - Flag gets inverted carry xor flag xor negative
// RULE3 - Step shifts result over quotient register left
// RULE4 - Init sets quotient flag, negative from operand sign
// RULE5 - Init shifts operand over quotient register, zero fill
// RULE6 - Immediate bit selects zero-extended 8-bit operand
// RULE7 - Last step writes unshifted sum, updates flags
// RULE8 - Last step shifts quotient register, flag fills
// RULE9 - Remainder fix copies or adds per flag
// RULE10 - Signed long divide traps, loads three pointers
// RULE11 - Emulation returns signed quotient and remainder
// RULE12 - Unsigned long divide traps, loads pointers
// RULE13 - Double multiply traps with pointers to pairs
// RULE14 - Double subtract traps with pointers to pairs
// RULE15 - Software trap loads two pointers, traps vector
// RULE16 - Software trap may alter third pointer
// RULE17 - User low vector or protected register: violation
// RULE18 - Primitives update status flags; traps do not
`timescale 1ns/1ps
`default_nettype none
module dst_core #(
    parameter int unsigned W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire dst_pkg::dst_instr_t instr,
    input wire dst_pkg::dst_operands_t operands,
    input wire logic user_mode,
    input wire logic a_protected,
    input wire logic b_protected,
    output logic [W-1:0] dest_data_q,
    output logic [7:0] dest_num_q,
    output logic dest_we_q,
    output logic [W-1:0] qreg_q,
    output logic quotient_flag_q,
    output logic [3:0] status_flags_q,
    output logic [7:0] first_operand_pointer_q,
    output logic [7:0] second_operand_pointer_q,
    output logic [7:0] dest_operand_pointer_q,
    output dst_pkg::dst_trap_t trap_q
);
    dst_pkg::dst_op_t op;
    logic use_imm;
    logic [W-1:0] src_a;
    logic [W-1:0] src_b;
    logic [W-1:0] as_a;
    logic [W-1:0] as_sum;
    logic as_carry;
    logic as_ovf;
    logic new_qflag;
    logic [2*W-1:0] pair;
    logic [W-1:0] step_ref;

    logic [W-1:0] dest_data_d;
    logic [7:0] dest_num_d;
    logic dest_we_d;
    logic [W-1:0] qreg_d;
    logic quotient_flag_d;
    logic [3:0] status_flags_d;
    logic [7:0] ptr_a_d;
    logic [7:0] ptr_b_d;
    logic [7:0] ptr_c_d;
    dst_pkg::dst_trap_t trap_d;

    dst_decode u_decode (
        .instr(instr),
        .instr_valid(instr_valid),
        .op(op),
        .use_imm(use_imm)
    );

    // Init has no add; remainder fix always adds
    dst_addsub #(.W(W)) u_addsub (
        .a(as_a),
        .b(src_b),
        .sub(quotient_flag_q && (op != dst_pkg::DST_OP_REMFIX)), // RULE1
        .sum(as_sum),
        .carry(as_carry),
        .ovf(as_ovf)
    );

    function automatic logic [3:0] flags_of(input logic [W-1:0] r,
                                            input logic c, input logic v);
        logic [3:0] f;
        f = '0;
        f[dst_pkg::FLAG_V] = v;
        f[dst_pkg::FLAG_N] = r[W-1];
        f[dst_pkg::FLAG_Z] = (r == '0);
        f[dst_pkg::FLAG_C] = c;
        return f;
    endfunction : flags_of

    always_comb
    begin
        src_a = operands.first_source;
        src_b = use_imm ? {{(W-8){1'b0}}, instr.b_num}
                        : operands.second_source; // RULE6
        as_a = src_a;
        new_qflag = ~(as_carry ^ quotient_flag_q
                      ^ status_flags_q[dst_pkg::FLAG_N]); // RULE2
        step_ref = quotient_flag_q ? src_a - src_b : src_a + src_b;
    end

    always_comb
    begin
        dest_data_d = dest_data_q;
        dest_num_d = dest_num_q;
        dest_we_d = 1'b0;
        qreg_d = qreg_q;
        quotient_flag_d = quotient_flag_q;
        status_flags_d = status_flags_q; // RULE18
        ptr_a_d = first_operand_pointer_q;
        ptr_b_d = second_operand_pointer_q;
        ptr_c_d = dest_operand_pointer_q;
        trap_d = '0;
        pair = '0;
        unique case (op)
            dst_pkg::DST_OP_INIT:
            begin
                quotient_flag_d = 1'b1; // RULE4
                pair = {src_b[W-2:0], qreg_q, 1'b0}; // RULE5
                dest_data_d = pair[2*W-1:W];
                qreg_d = pair[W-1:0];
                dest_num_d = instr.dest_num;
                dest_we_d = 1'b1;
                status_flags_d = flags_of(pair[2*W-1:W], 1'b0, 1'b0);
                status_flags_d[dst_pkg::FLAG_N] = src_b[W-1]; // RULE4
            end
            dst_pkg::DST_OP_STEP:
            begin
                quotient_flag_d = new_qflag; // RULE2
                pair = {as_sum[W-2:0], qreg_q, new_qflag}; // RULE3
                dest_data_d = pair[2*W-1:W];
                qreg_d = pair[W-1:0];
                dest_num_d = instr.dest_num;
                dest_we_d = 1'b1;
                status_flags_d = flags_of(as_sum, as_carry, as_ovf); // RULE18
            end
            dst_pkg::DST_OP_FINAL:
            begin
                quotient_flag_d = new_qflag; // RULE7
                dest_data_d = as_sum; // RULE7
                qreg_d = {qreg_q[W-2:0], new_qflag}; // RULE8
                dest_num_d = instr.dest_num;
                dest_we_d = 1'b1;
                status_flags_d = flags_of(as_sum, as_carry, as_ovf); // RULE18
            end
            dst_pkg::DST_OP_REMFIX:
            begin
                dest_data_d = quotient_flag_q ? src_a : as_sum; // RULE9
                dest_num_d = instr.dest_num;
                dest_we_d = 1'b1;
                status_flags_d = flags_of(dest_data_d, as_carry && !quotient_flag_q,
                                          as_ovf && !quotient_flag_q);
            end
            dst_pkg::DST_OP_TRAP3:
            begin
                // Emulation routine produces the result via the pointers
                ptr_a_d = instr.a_num; // RULE10 RULE12 RULE13 RULE14
                ptr_b_d = instr.b_num; // RULE10 RULE12 RULE13 RULE14
                ptr_c_d = instr.dest_num; // RULE10 RULE12 RULE13 RULE14
                trap_d.valid = 1'b1; // RULE11
                trap_d.vector = instr.opcode; // RULE10 RULE12 RULE13 RULE14
            end
            dst_pkg::DST_OP_SWTRAP:
            begin
                ptr_a_d = instr.a_num; // RULE15
                ptr_b_d = instr.b_num; // RULE15
                ptr_c_d = instr.dest_num; // RULE16
                trap_d.valid = 1'b1;
                if (user_mode
                    && (instr.dest_num <= dst_pkg::VEC_USER_LIMIT
                    || a_protected || b_protected))
                    trap_d.vector = dst_pkg::VEC_PROTECTION; // RULE17
                else
                    trap_d.vector = instr.dest_num; // RULE15
            end
            dst_pkg::DST_OP_NONE:
            begin
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dest_data_q <= '0;
            dest_num_q <= dst_pkg::PTR_RESET;
            dest_we_q <= 1'b0;
            qreg_q <= dst_pkg::QREG_RESET;
            quotient_flag_q <= dst_pkg::QFLAG_RESET;
            status_flags_q <= dst_pkg::FLAGS_RESET;
            first_operand_pointer_q <= dst_pkg::PTR_RESET;
            second_operand_pointer_q <= dst_pkg::PTR_RESET;
            dest_operand_pointer_q <= dst_pkg::PTR_RESET;
            trap_q <= '0;
        end
        else
        begin
            dest_data_q <= dest_data_d;
            dest_num_q <= dest_num_d;
            dest_we_q <= dest_we_d;
            qreg_q <= qreg_d;
            quotient_flag_q <= quotient_flag_d;
            status_flags_q <= status_flags_d;
            first_operand_pointer_q <= ptr_a_d;
            second_operand_pointer_q <= ptr_b_d;
            dest_operand_pointer_q <= ptr_c_d;
            trap_q <= trap_d;
        end
    end

    sequence s_prim_issued;
        (op == dst_pkg::DST_OP_INIT) || (op == dst_pkg::DST_OP_STEP)
        || (op == dst_pkg::DST_OP_FINAL) || (op == dst_pkg::DST_OP_REMFIX);
    endsequence

    sequence s_trap_issued;
        (op == dst_pkg::DST_OP_TRAP3) || (op == dst_pkg::DST_OP_SWTRAP);
    endsequence

    chk_step_sub_sel: assert property ( // RULE1
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_STEP) |=> dest_data_q
        == {$past(step_ref[W-2:0]), $past(qreg_q[W-1])})
        else $error("step add or subtract wrong");
    chk_step_flag_q0: assert property ( // RULE3
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_STEP) |=> qreg_q[0] == quotient_flag_q)
        else $error("step fill bit differs from flag");
    chk_step_flag_eq: assert property ( // RULE2
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_STEP) |=>
        quotient_flag_q == ~($past(as_carry) ^ $past(quotient_flag_q)
        ^ $past(status_flags_q[dst_pkg::FLAG_N])))
        else $error("quotient flag equation wrong");
    chk_step_neg: assert property ( // RULE2
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_STEP) || (op == dst_pkg::DST_OP_FINAL) |=>
        status_flags_q[dst_pkg::FLAG_N] == $past(step_ref[W-1]))
        else $error("negative flag not result sign");
    chk_init_flag: assert property ( // RULE4
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_INIT) |=> quotient_flag_q
        && status_flags_q[dst_pkg::FLAG_N] == $past(src_b[W-1]))
        else $error("init flags wrong");
    chk_init_shift: assert property ( // RULE5
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_INIT) |=> qreg_q[0] == 1'b0
        && dest_data_q == {$past(src_b[W-2:0]), $past(qreg_q[W-1])})
        else $error("init shift wrong");
    chk_imm_zero_ext: assert property ( // RULE6
        @(posedge ref_clk) disable iff (rst)
        use_imm |-> src_b == {{(W-8){1'b0}}, instr.b_num})
        else $error("immediate not zero extended");
    chk_final_result: assert property ( // RULE7
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_FINAL) |=> dest_data_q == $past(step_ref))
        else $error("last step result wrong");
    chk_final_qreg: assert property ( // RULE8
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_FINAL) |=>
        qreg_q == {$past(qreg_q[W-2:0]), quotient_flag_q})
        else $error("last step quotient shift wrong");
    chk_remfix_copy: assert property ( // RULE9
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_REMFIX) |=> dest_data_q ==
        ($past(quotient_flag_q) ? $past(src_a) : $past(src_a + src_b)))
        else $error("remainder fix wrong");
    chk_trap_ptrs: assert property ( // RULE10
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_TRAP3) |=> trap_q.valid
        && first_operand_pointer_q == $past(instr.a_num)
        && second_operand_pointer_q == $past(instr.b_num)
        && dest_operand_pointer_q == $past(instr.dest_num))
        else $error("trap pointers wrong");
    chk_trap_vector: assert property ( // RULE12
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_TRAP3) |=>
        trap_q.vector == $past(instr.opcode))
        else $error("dedicated trap vector wrong");
    chk_swtrap_prot: assert property ( // RULE17
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_SWTRAP) && user_mode
        && (a_protected || b_protected) |=>
        trap_q.vector == dst_pkg::VEC_PROTECTION)
        else $error("protection trap missed");
    chk_swtrap_user: assert property ( // RULE17
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_SWTRAP) && user_mode
        && (instr.dest_num <= dst_pkg::VEC_USER_LIMIT) |=>
        trap_q.vector == dst_pkg::VEC_PROTECTION)
        else $error("user low vector not refused");
    chk_swtrap_vec: assert property ( // RULE15
        @(posedge ref_clk) disable iff (rst)
        (op == dst_pkg::DST_OP_SWTRAP) && !user_mode |=> trap_q.valid
        && trap_q.vector == $past(instr.dest_num)
        && first_operand_pointer_q == $past(instr.a_num)
        && second_operand_pointer_q == $past(instr.b_num))
        else $error("software trap vector or pointers wrong");
    chk_trap_flags: assert property ( // RULE18
        @(posedge ref_clk) disable iff (rst)
        s_trap_issued |=> $stable(status_flags_q) && !dest_we_q)
        else $error("trap altered flags");
    chk_trap_state: assert property ( // RULE13
        @(posedge ref_clk) disable iff (rst)
        s_trap_issued |=> $stable(qreg_q) && $stable(quotient_flag_q))
        else $error("trap altered quotient state");
    chk_prim_write: assert property ( // RULE18
        @(posedge ref_clk) disable iff (rst)
        s_prim_issued |=> dest_we_q && !trap_q.valid)
        else $error("primitive did not write");
endmodule : dst_core
`default_nettype wire

// ---- include/dst_pkg.sv ----
// Shared types and constants for the divide-step and trap datapath
package dst_pkg;

    localparam int unsigned WORD_W = 32;
    localparam int unsigned REG_NUM_W = 8;
    localparam int unsigned OPC_W = 8;
    localparam int unsigned VEC_W = 8;

    // Opcodes (bit 0 of the divide-primitive opcodes selects immediate)
    localparam logic [7:0] OPC_STEP_R = 8'h6a;
    localparam logic [7:0] OPC_STEP_I = 8'h6b;
    localparam logic [7:0] OPC_INIT_R = 8'h68;
    localparam logic [7:0] OPC_INIT_I = 8'h69;
    localparam logic [7:0] OPC_FINAL_R = 8'h6c;
    localparam logic [7:0] OPC_FINAL_I = 8'h6d;
    localparam logic [7:0] OPC_REMFIX_R = 8'h6e;
    localparam logic [7:0] OPC_REMFIX_I = 8'h6f;
    localparam logic [7:0] OPC_SIGNED_LONG_DIV = 8'he1;
    localparam logic [7:0] OPC_UNSIGNED_LONG_DIV = 8'he3;
    localparam logic [7:0] OPC_DOUBLE_PRODUCT = 8'hf5;
    localparam logic [7:0] OPC_DOUBLE_DIFFERENCE = 8'hf3;
    localparam logic [7:0] OPC_SOFTWARE_TRAP = 8'hf8;

    // Trap vectors for the dedicated traps and protection violation, and the user vector limit
    localparam logic [7:0] VEC_SIGNED_LONG_DIV = 8'he1;
    localparam logic [7:0] VEC_UNSIGNED_LONG_DIV = 8'he3;
    localparam logic [7:0] VEC_DOUBLE_PRODUCT = 8'hf5;
    localparam logic [7:0] VEC_DOUBLE_DIFFERENCE = 8'hf3;
    localparam logic [7:0] VEC_PROTECTION = 8'h05;
    localparam logic [7:0] VEC_USER_LIMIT = 8'h3f;

    // Reset values
    localparam logic [31:0] QREG_RESET = 32'h0000_0000;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic QFLAG_RESET = 1'b0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // Flag field positions in the packed status
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_C = 0;

    typedef enum logic [2:0] {
        DST_OP_NONE,
        DST_OP_INIT,
        DST_OP_STEP,
        DST_OP_FINAL,
        DST_OP_REMFIX,
        DST_OP_TRAP3,
        DST_OP_SWTRAP
    } dst_op_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] dest_num;
        logic [7:0] a_num;
        logic [7:0] b_num;
    } dst_instr_t;

    typedef struct packed {
        logic [31:0] first_source;
        logic [31:0] second_source;
    } dst_operands_t;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
    } dst_trap_t;

endpackage : dst_pkg

// ---- logic/dst_decode.sv ----
// Instruction decoder for the divide-step and trap datapath
`timescale 1ns/1ps
`default_nettype none
module dst_decode (
    input wire dst_pkg::dst_instr_t instr,
    input wire logic instr_valid,
    output dst_pkg::dst_op_t op,
    output logic use_imm
);
    always_comb
    begin
        op = dst_pkg::DST_OP_NONE;
        use_imm = 1'b0;
        if (instr_valid)
        begin
            unique case (instr.opcode)
                dst_pkg::OPC_INIT_R, dst_pkg::OPC_INIT_I:
                    op = dst_pkg::DST_OP_INIT;
                dst_pkg::OPC_STEP_R, dst_pkg::OPC_STEP_I:
                    op = dst_pkg::DST_OP_STEP;
                dst_pkg::OPC_FINAL_R, dst_pkg::OPC_FINAL_I:
                    op = dst_pkg::DST_OP_FINAL;
                dst_pkg::OPC_REMFIX_R, dst_pkg::OPC_REMFIX_I:
                    op = dst_pkg::DST_OP_REMFIX;
                dst_pkg::OPC_SIGNED_LONG_DIV, dst_pkg::OPC_UNSIGNED_LONG_DIV,
                dst_pkg::OPC_DOUBLE_PRODUCT, dst_pkg::OPC_DOUBLE_DIFFERENCE:
                    op = dst_pkg::DST_OP_TRAP3;
                dst_pkg::OPC_SOFTWARE_TRAP:
                    op = dst_pkg::DST_OP_SWTRAP;
                default:
                    op = dst_pkg::DST_OP_NONE;
            endcase
            // Immediate select is bit 0 of the primitive opcodes
            use_imm = instr.opcode[0] && (instr.opcode[7:4] == 4'h6); // RULE6
        end
    end
endmodule : dst_decode
`default_nettype wire

// ---- logic/dst_addsub.sv ----
// Add or subtract unit with carry and overflow
`timescale 1ns/1ps
`default_nettype none
module dst_addsub #(
    parameter int unsigned W = 32
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic sub,
    output logic [W-1:0] sum,
    output logic carry,
    output logic ovf
);
    logic [W:0] full;
    logic [W-1:0] b_eff;

    always_comb
    begin
        b_eff = sub ? ~b : b;
        full = {1'b0, a} + {1'b0, b_eff} + {{W{1'b0}}, sub};
        sum = full[W-1:0];
        carry = full[W];
        ovf = (a[W-1] == b_eff[W-1]) && (sum[W-1] != a[W-1]);
    end
endmodule : dst_addsub
`default_nettype wire

// ---- testbench/divide_step_and_trap_ops_tb_top.sv ----
// Self-checking bench for the divide-step and trap datapath
`timescale 1ns/1ps
`default_nettype none
module divide_step_and_trap_ops_tb_top;
    logic ref_clk;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    dst_pkg::dst_instr_t instr = '0;
    dst_pkg::dst_operands_t operands = '0;
    logic user_mode = 1'b0;
    logic a_protected = 1'b0;
    logic b_protected = 1'b0;
    logic [31:0] dest_data_q;
    logic [7:0] dest_num_q;
    logic dest_we_q;
    logic [31:0] qreg_q;
    logic quotient_flag_q;
    logic [3:0] status_flags_q;
    logic [7:0] first_operand_pointer_q;
    logic [7:0] second_operand_pointer_q;
    logic [7:0] dest_operand_pointer_q;
    dst_pkg::dst_trap_t trap_q;
    int fail_count = 0;
    int samples_checked = 0;
    int seed_init;
    // Reference model state
    logic [31:0] m_q = '0;
    logic [31:0] m_dest = '0;
    logic m_df = 1'b0;
    logic [3:0] m_fl = '0;
    logic [7:0] m_pa, m_pb, m_pc, m_dnum, e_vec;
    logic e_we, e_trap, e_ptr, e_pc;
    logic [3:0] e_fmask;
    logic pend = 1'b0;
    logic [7:0] trap_ops [4] = '{8'he1, 8'he3, 8'hf5, 8'hf3};
    logic [7:0] sw_vec [7] = '{8'h10, 8'h40, 8'h3f, 8'h40, 8'h40, 8'h00,
                              8'hff};
    logic [2:0] sw_prot [7] = '{3'h0, 3'h4, 3'h4, 3'h6, 3'h5, 3'h4, 3'h3};

    dst_core #(.W(32)) i_dst_core (
        .ref_clk(ref_clk),
        .rst(rst),
        .instr_valid(instr_valid),
        .instr(instr),
        .operands(operands),
        .user_mode(user_mode),
        .a_protected(a_protected),
        .b_protected(b_protected),
        .dest_data_q(dest_data_q),
        .dest_num_q(dest_num_q),
        .dest_we_q(dest_we_q),
        .qreg_q(qreg_q),
        .quotient_flag_q(quotient_flag_q),
        .status_flags_q(status_flags_q),
        .first_operand_pointer_q(first_operand_pointer_q),
        .second_operand_pointer_q(second_operand_pointer_q),
        .dest_operand_pointer_q(dest_operand_pointer_q),
        .trap_q(trap_q)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask : cmp

    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // Carry is no-borrow on subtract
    task automatic addsub(input logic [31:0] a, input logic [31:0] b,
                          input logic sub, output logic [31:0] r,
                          output logic c, output logic v);
        logic [32:0] s;
        s = sub ? {1'b0, a} + {1'b0, ~b} + 33'h1 : {1'b0, a} + {1'b0, b};
        r = s[31:0];
        c = s[32];
        v = (sub ? a[31] != b[31] : a[31] == b[31]) && (r[31] != a[31]);
    endtask : addsub

    task automatic check_prev;
        cmp(dest_we_q, e_we, "write strobe");
        cmp(trap_q.valid, e_trap, "trap strobe");
        if (e_trap)
            cmp(trap_q.vector, e_vec, "trap vector");
        if (e_we)
        begin
            cmp(dest_data_q, m_dest, "dest data");
            cmp(dest_num_q, m_dnum, "dest number");
        end
        cmp(qreg_q, m_q, "quotient register");
        cmp(quotient_flag_q, m_df, "quotient flag");
        cmp(status_flags_q & e_fmask, m_fl & e_fmask, "status");
        if (e_ptr)
        begin
            cmp(first_operand_pointer_q, m_pa, "first pointer");
            cmp(second_operand_pointer_q, m_pb, "second pointer");
        end
        if (e_pc)
            cmp(dest_operand_pointer_q, m_pc, "dest pointer");
    endtask : check_prev

    // Drive one instruction, check the previous one, then model this one
    task automatic issue(input logic [7:0] opc, input logic [7:0] dn,
                         input logic [7:0] an, input logic [7:0] bn,
                         input logic [31:0] fa, input logic [31:0] fb,
                         input logic v, input logic [2:0] prot);
        logic [31:0] b;
        logic [31:0] r;
        logic c;
        logic ov;
        logic nd;
        @(posedge ref_clk);
        instr <= {opc, dn, an, bn};
        operands <= {fa, fb};
        instr_valid <= v;
        {user_mode, a_protected, b_protected} <= prot;
        #1;
        if (pend)
            check_prev();
        pend = 1'b1;
        e_we = 1'b0;
        e_trap = 1'b0;
        e_ptr = 1'b0;
        e_pc = 1'b0;
        e_fmask = 4'hf;
        b = (opc[7:4] == 4'h6 && opc[0]) ? {24'h0, bn} : fb;
        if (v)
        begin
            case (opc)
                8'h68, 8'h69:
                begin
                    m_dest = {b[30:0], m_q[31]};
                    m_q = {m_q[30:0], 1'b0};
                    m_df = 1'b1;
                    m_fl = {1'b0, b[31], m_dest == 32'h0, 1'b0};
                    e_we = 1'b1;
                    m_dnum = dn;
                end
                8'h6a, 8'h6b, 8'h6c, 8'h6d:
                begin
                    addsub(fa, b, m_df, r, c, ov);
                    nd = ~(c ^ m_df ^ m_fl[2]);
                    m_dest = opc[2] ? r : {r[30:0], m_q[31]};
                    m_q = {m_q[30:0], nd};
                    m_df = nd;
                    m_fl = {ov, r[31], r == 32'h0, c};
                    e_we = 1'b1;
                    m_dnum = dn;
                end
                8'h6e, 8'h6f:
                begin
                    addsub(fa, b, 1'b0, r, c, ov);
                    if (m_df)
                        {m_dest, m_fl} = {fa, 1'b0, fa[31], fa == 32'h0, 1'b0};
                    else
                        {m_dest, m_fl} = {r, ov, r[31], r == 32'h0, c};
                    e_we = 1'b1;
                    m_dnum = dn;
                end
                8'he1, 8'he3, 8'hf5, 8'hf3:
                begin
                    {e_trap, e_vec} = {1'b1, opc};
                    {m_pa, m_pb, m_pc} = {an, bn, dn};
                    {e_ptr, e_pc} = 2'b11;
                end
                8'hf8:
                begin
                    e_trap = 1'b1;
                    if (prot[2] && (dn <= 8'h3f || prot[1] || prot[0]))
                        e_vec = dst_pkg::VEC_PROTECTION;
                    else
                        {e_vec, m_pa, m_pb, e_ptr} = {dn, an, bn, 1'b1};
                end
                default: ;
            endcase
        end
    endtask : issue

    initial
    begin
        logic [31:0] hi, lo, dv;
        logic [63:0] num;
        seed_init = $urandom(19);
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        cmp({dest_we_q, trap_q.valid, quotient_flag_q, status_flags_q}, '0,
            "reset strobes");
        cmp(qreg_q, '0, "reset qreg");
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            dv = ($urandom >> 1) >> (k * 7);
            dv = (dv == 32'h0) ? 32'h7 : dv;
            hi = $urandom % dv;
            lo = m_q;
            issue(8'h68, 8'h10, 8'h0, 8'h0, 32'h0, hi, 1'b1, 3'h0);
            for (int s = 0; s < 31; s++)
                issue(8'h6a, 8'h10, 8'h10, 8'h11, m_dest, dv, 1'b1, 3'h0);
            issue(8'h6c, 8'h10, 8'h10, 8'h11, m_dest, dv, 1'b1, 3'h0);
            issue(8'h6e, 8'h12, 8'h10, 8'h11, m_dest, dv, 1'b1, 3'h0);
            issue(8'h00, 8'h0, 8'h0, 8'h0, 32'h0, 32'h0, 1'b0, 3'h0);
            num = {hi, lo};
            cmp(qreg_q, 32'(num / dv), "quotient");
            cmp(dest_data_q, 32'(num % dv), "remainder");
        end
        $display("test division done");
        for (int k = 0; k < 80; k++)
            issue(8'h68 + 8'($urandom % 8), 8'($urandom), 8'($urandom),
                  8'($urandom), $urandom, $urandom, 1'b1, 3'($urandom));
        $display("test random primitives done");
        foreach (trap_ops[i])
        begin
            issue(trap_ops[i], 8'($urandom), 8'($urandom),
                  8'($urandom), $urandom, $urandom, 1'b1, 3'h4);
            issue(8'h6a, 8'h1, 8'h2, 8'h3, $urandom, $urandom, 1'b1, 3'h0);
        end
        $display("test dedicated traps done");
        for (int k = 0; k < 7; k++)
            issue(8'hf8, sw_vec[k], 8'($urandom), 8'($urandom),
                  $urandom, $urandom, 1'b1, sw_prot[k]);
        $display("test software trap done");
        issue(8'h00, 8'h5, 8'h6, 8'h7, $urandom, $urandom, 1'b1, 3'h0);
        issue(8'h6a, 8'h5, 8'h6, 8'h7, $urandom, $urandom, 1'b0, 3'h0);
        issue(8'h6e, 8'h5, 8'h6, 8'h7, $urandom, $urandom, 1'b1, 3'h0);
        issue(8'h00, 8'h0, 8'h0, 8'h0, 32'h0, 32'h0, 1'b0, 3'h0);
        $display("test refused ops done");
        test_done();
    end

    initial
    begin
        #8000;
        fail_count++;
        test_done();
    end
endmodule : divide_step_and_trap_ops_tb_top
`default_nettype wire
